// ==== acc_load_pkg.sv ====
// Contract
// - Timer 4 high to companion, low to accumulator
// - Conversion mode: result 9-6 and 5-2 loaded
// - Compare mode: result 7-4 and 3-0 loaded
// - General register nibbles to companion and accumulator
// - ROM fetch: page, index, accumulator address; three cycles
// - ROM fetch pushes, clears index bit 2, pops
// - Prescaler high to companion, low to accumulator
// - Serial shift nibbles to companion and accumulator
// - Page index to accumulator, bit 3 cleared
// - Compare reference write only in compare mode
// - Selected interrupt control register to accumulator
// - Serial control register to accumulator, unit untouched
// - Selected wakeup control register to accumulator
// - Result low bits to accumulator top, rest cleared
// - RAM word to accumulator; row index XOR immediate
// - Clock control register to accumulator
// - Selected pull-up control register to accumulator
// - First conversion control register to accumulator
package acc_load_pkg;
   localparam int INSTR_W     = 10;
   localparam int PC_W        = 13;
   localparam int PAGE_W      = 6;
   localparam int STACK_DEPTH = 8;
   localparam int CMP_MODE_BIT = 3;

   localparam logic [9:0] OP_READ_TIMER4_PAIR      = 10'h27b;
   localparam logic [9:0] OP_READ_CONVERSION_RESULT = 10'h279;
   localparam logic [9:0] OP_READ_GENERAL_PAIR     = 10'h02a;
   localparam logic [9:0] OP_READ_PRESCALER        = 10'h275;
   localparam logic [9:0] OP_READ_SERIAL_SHIFT     = 10'h278;
   localparam logic [9:0] OP_READ_PAGE_INDEX       = 10'h051;
   localparam logic [9:0] OP_WRITE_COMPARE_REF     = 10'h239;
   localparam logic [9:0] OP_READ_INT_CTRL_FIRST   = 10'h253;
   localparam logic [9:0] OP_READ_INT_CTRL_SECOND  = 10'h254;
   localparam logic [9:0] OP_READ_SERIAL_CTRL      = 10'h242;
   localparam logic [9:0] OP_READ_WAKE_CTRL_ZERO   = 10'h256;
   localparam logic [9:0] OP_READ_WAKE_CTRL_ONE    = 10'h259;
   localparam logic [9:0] OP_READ_WAKE_CTRL_TWO    = 10'h25a;
   localparam logic [9:0] OP_READ_RESULT_LOW_BITS  = 10'h249;
   localparam logic [9:0] OP_READ_CLOCK_CTRL       = 10'h252;
   localparam logic [9:0] OP_READ_PULLUP_CTRL_ZERO = 10'h257;
   localparam logic [9:0] OP_READ_PULLUP_CTRL_ONE  = 10'h25e;
   localparam logic [9:0] OP_READ_CONV_CTRL_FIRST  = 10'h244;
   // Families with an immediate field: upper bits compared only
   localparam logic [5:0] OP_LOAD_ACC_FROM_RAM_HI  = 6'h2c;
   localparam logic [3:0] OP_ROM_CONSTANT_FETCH_HI = 4'h2;

   localparam logic [3:0] ACC_RESET   = 4'h0;
   localparam logic [2:0] PAGE_RESET  = 3'h0;
   localparam logic [3:0] ROW_RESET   = 4'h0;
   localparam logic [7:0] REF_RESET   = 8'h00;

   typedef enum logic [1:0] {
      FETCH_IDLE = 2'b00,
      FETCH_WAIT = 2'b01,
      FETCH_LOAD = 2'b10
   } fetch_state_type;
endpackage

// ==== return_stack.sv ====
`timescale 1ns/1ps
`default_nettype none
module return_stack #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 8,
   parameter int LVL_W = 3
) (
   input  wire logic             clk,      // Instruction clock
   input  wire logic             rst_b,    // Async reset, active low
   input  wire logic             push,     // Store word, advance level
   input  wire logic [WIDTH-1:0] pushWord, // Word to store
   input  wire logic             pop,      // Drop top word
   output logic      [WIDTH-1:0] topWord,  // Word at current level
   output logic      [LVL_W-1:0] level     // Current level pointer
);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [LVL_W-1:0] level_q;
   logic [LVL_W-1:0] level_d;
   logic [LVL_W-1:0] wrIdx;

   // Pointer wraps silently; overflow is the program's concern
   always_comb begin
      wrIdx   = level_q + LVL_W'(1);
      level_d = level_q;
      mem_d   = mem_q;
      if (push) begin
         level_d = wrIdx;
         mem_d[wrIdx] = pushWord;
      end else if (pop) begin
         level_d = level_q - LVL_W'(1);
      end
   end

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : gEntry
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               mem_q[g] <= '0;
            end else begin
               mem_q[g] <= mem_d[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         level_q <= '1;
      end else begin
         level_q <= level_d;
      end
   end

   assign topWord = mem_q[level_q];
   assign level   = level_q;
endmodule
`default_nettype wire

// ==== accumulator_load_instructions.sv ====
`timescale 1ns/1ps
`default_nettype none
module accumulator_load_instructions #(
   parameter int PC_W   = acc_load_pkg::PC_W,
   parameter int PAGE_W = acc_load_pkg::PAGE_W,
   parameter int DEPTH  = acc_load_pkg::STACK_DEPTH
) (
   input  wire logic              clk,             // Instruction clock
   input  wire logic              rst_b,           // Async reset, low
   input  wire logic [9:0]        instr,           // Instruction word
   input  wire logic              instrValid,      // Instruction present
   input  wire logic [7:0]        timer4Val,       // Timer 4 count
   input  wire logic [9:0]        convResult,      // Conversion result
   input  wire logic [3:0]        convCtrlFirst,   // Conv control reg 1
   input  wire logic [7:0]        generalReg,      // General 8-bit reg
   input  wire logic [7:0]        prescalerVal,    // Prescaler count
   input  wire logic [7:0]        serialShift,     // Serial shift reg
   input  wire logic [3:0]        intCtrlFirst,    // Interrupt ctrl 1
   input  wire logic [3:0]        intCtrlSecond,   // Interrupt ctrl 2
   input  wire logic [3:0]        serialCtrl,      // Serial control reg
   input  wire logic [3:0]        wakeCtrl0,       // Wakeup control 0
   input  wire logic [3:0]        wakeCtrl1,       // Wakeup control 1
   input  wire logic [3:0]        wakeCtrl2,       // Wakeup control 2
   input  wire logic [3:0]        clockCtrl,       // Clock control reg
   input  wire logic [3:0]        pullupCtrl0,     // Pull-up control 0
   input  wire logic [3:0]        pullupCtrl1,     // Pull-up control 1
   input  wire logic [3:0]        ramData,         // RAM word at pointer
   input  wire logic [PC_W-1:0]   pcIn,            // Current PC
   input  wire logic [9:0]        romData,         // ROM word read back
   output logic      [3:0]        accOut,          // Accumulator
   output logic      [3:0]        compOut,         // Companion register
   output logic      [2:0]        pageIndexOut,    // Page index reg
   output logic      [3:0]        rowIndexOut,     // Row index reg
   output logic      [7:0]        compareRef,      // Comparator ref
   output logic                   compareRefWrite, // Ref written pulse
   output logic      [PC_W-1:0]   romAddr,         // ROM fetch address
   output logic                   romRead,         // ROM read strobe
   output logic                   busy,            // Fetch in progress
   output logic                   pcRestore,       // PC reload pulse
   output logic      [PC_W-1:0]   pcRestoreValue,  // PC to reload
   output logic      [$clog2(DEPTH)-1:0] stackLevel // Stack pointer
);
   localparam int LVL_W = $clog2(DEPTH);
   localparam int LOW_W = PC_W - PAGE_W;

   acc_load_pkg::fetch_state_type state_q;
   acc_load_pkg::fetch_state_type state_d;
   logic [3:0]        acc_q;
   logic [3:0]        acc_d;
   logic [3:0]        comp_q;
   logic [3:0]        comp_d;
   logic [2:0]        page_q;
   logic [2:0]        page_d;
   logic [3:0]        row_q;
   logic [3:0]        row_d;
   logic [7:0]        ref_q;
   logic [7:0]        ref_d;
   logic              refWr_q;
   logic              refWr_d;
   logic [PC_W-1:0]   romAddr_q;
   logic [PC_W-1:0]   romAddr_d;
   logic              romRead_q;
   logic              romRead_d;
   logic              pcRest_q;
   logic              pcRest_d;
   logic [PC_W-1:0]   pcVal_q;
   logic [PC_W-1:0]   pcVal_d;
   logic              push;
   logic              pop;
   logic [PC_W-1:0]   stackTop;
   logic [LVL_W-1:0]  level;
   logic              cmpMode;
   logic              take;

   assign cmpMode = convCtrlFirst[acc_load_pkg::CMP_MODE_BIT];
   assign take    = instrValid && (state_q == acc_load_pkg::FETCH_IDLE);

   return_stack #(
      .WIDTH (PC_W),
      .DEPTH (DEPTH),
      .LVL_W (LVL_W)
   ) uStack (
      .clk      (clk),
      .rst_b    (rst_b),
      .push     (push),
      .pushWord (pcIn),
      .pop      (pop),
      .topWord  (stackTop),
      .level    (level)
   );

   // Single-cycle transfers except the three-cycle ROM fetch; carry and skip are never touched
   always_comb begin
      acc_d     = acc_q;
      comp_d    = comp_q;
      page_d    = page_q;
      row_d     = row_q;
      ref_d     = ref_q;
      refWr_d   = 1'b0;
      romAddr_d = romAddr_q;
      romRead_d = 1'b0;
      pcRest_d  = 1'b0;
      pcVal_d   = pcVal_q;
      state_d   = state_q;
      push      = 1'b0;
      pop       = 1'b0;
      case (state_q)
         acc_load_pkg::FETCH_IDLE: begin
            if (take) begin
               case (instr)
                  acc_load_pkg::OP_READ_TIMER4_PAIR: begin
                     comp_d = timer4Val[7:4];
                     acc_d  = timer4Val[3:0];
                  end
                  acc_load_pkg::OP_READ_CONVERSION_RESULT: begin
                     if (cmpMode) begin
                        comp_d = convResult[7:4];
                        acc_d  = convResult[3:0];
                     end else begin
                        comp_d = convResult[9:6];
                        acc_d  = convResult[5:2];
                     end
                  end
                  acc_load_pkg::OP_READ_GENERAL_PAIR: begin
                     comp_d = generalReg[7:4];
                     acc_d  = generalReg[3:0];
                  end
                  acc_load_pkg::OP_READ_PRESCALER: begin
                     comp_d = prescalerVal[7:4];
                     acc_d  = prescalerVal[3:0];
                  end
                  acc_load_pkg::OP_READ_SERIAL_SHIFT: begin
                     comp_d = serialShift[7:4];
                     acc_d  = serialShift[3:0];
                  end
                  acc_load_pkg::OP_READ_PAGE_INDEX: begin
                     acc_d = {1'b0, page_q};
                  end
                  acc_load_pkg::OP_WRITE_COMPARE_REF: begin
                     if (cmpMode) begin
                        ref_d   = {comp_q, acc_q};
                        refWr_d = 1'b1;
                     end
                  end
                  acc_load_pkg::OP_READ_INT_CTRL_FIRST: begin
                     acc_d = intCtrlFirst;
                  end
                  acc_load_pkg::OP_READ_INT_CTRL_SECOND: begin
                     acc_d = intCtrlSecond;
                  end
                  acc_load_pkg::OP_READ_SERIAL_CTRL: begin
                     acc_d = serialCtrl;
                  end
                  acc_load_pkg::OP_READ_WAKE_CTRL_ZERO: begin
                     acc_d = wakeCtrl0;
                  end
                  acc_load_pkg::OP_READ_WAKE_CTRL_ONE: begin
                     acc_d = wakeCtrl1;
                  end
                  acc_load_pkg::OP_READ_WAKE_CTRL_TWO: begin
                     acc_d = wakeCtrl2;
                  end
                  acc_load_pkg::OP_READ_RESULT_LOW_BITS: begin
                     acc_d = {convResult[1:0], 2'b00};
                  end
                  acc_load_pkg::OP_READ_CLOCK_CTRL: begin
                     acc_d = clockCtrl;
                  end
                  acc_load_pkg::OP_READ_PULLUP_CTRL_ZERO: begin
                     acc_d = pullupCtrl0;
                  end
                  acc_load_pkg::OP_READ_PULLUP_CTRL_ONE: begin
                     acc_d = pullupCtrl1;
                  end
                  acc_load_pkg::OP_READ_CONV_CTRL_FIRST: begin
                     acc_d = convCtrlFirst;
                  end
                  default: begin
                     if (instr[9:4] == acc_load_pkg::OP_LOAD_ACC_FROM_RAM_HI)
                     begin
                        acc_d = ramData;
                        row_d = row_q ^ instr[3:0];
                     end else if (instr[9:6] ==
                                  acc_load_pkg::OP_ROM_CONSTANT_FETCH_HI)
                     begin
                        push      = 1'b1;
                        romAddr_d = {PAGE_W'(instr[5:0]),
                                     LOW_W'({page_q, acc_q})};
                        romRead_d = 1'b1;
                        state_d   = acc_load_pkg::FETCH_WAIT;
                     end
                  end
               endcase
            end
         end
         acc_load_pkg::FETCH_WAIT: begin
            state_d = acc_load_pkg::FETCH_LOAD;
         end
         acc_load_pkg::FETCH_LOAD: begin
            page_d   = {1'b0, romData[9:8]};
            comp_d   = romData[7:4];
            acc_d    = romData[3:0];
            pcVal_d  = stackTop;
            pcRest_d = 1'b1;
            pop      = 1'b1;
            state_d  = acc_load_pkg::FETCH_IDLE;
         end
         default: begin
            state_d = acc_load_pkg::FETCH_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q   <= acc_load_pkg::FETCH_IDLE;
         acc_q     <= acc_load_pkg::ACC_RESET;
         comp_q    <= acc_load_pkg::ACC_RESET;
         page_q    <= acc_load_pkg::PAGE_RESET;
         row_q     <= acc_load_pkg::ROW_RESET;
         ref_q     <= acc_load_pkg::REF_RESET;
         refWr_q   <= 1'b0;
         romAddr_q <= '0;
         romRead_q <= 1'b0;
         pcRest_q  <= 1'b0;
         pcVal_q   <= '0;
      end else begin
         state_q   <= state_d;
         acc_q     <= acc_d;
         comp_q    <= comp_d;
         page_q    <= page_d;
         row_q     <= row_d;
         ref_q     <= ref_d;
         refWr_q   <= refWr_d;
         romAddr_q <= romAddr_d;
         romRead_q <= romRead_d;
         pcRest_q  <= pcRest_d;
         pcVal_q   <= pcVal_d;
      end
   end

   logic busy_q;
   logic [LVL_W-1:0] stackLevel_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_q       <= 1'b0;
         stackLevel_q <= '1;
      end else begin
         busy_q       <= (state_d != acc_load_pkg::FETCH_IDLE);
         stackLevel_q <= level;
      end
   end

   assign accOut          = acc_q;
   assign compOut         = comp_q;
   assign pageIndexOut    = page_q;
   assign rowIndexOut     = row_q;
   assign compareRef      = ref_q;
   assign compareRefWrite = refWr_q;
   assign romAddr         = romAddr_q;
   assign romRead         = romRead_q;
   assign busy            = busy_q;
   assign pcRestore       = pcRest_q;
   assign pcRestoreValue  = pcVal_q;
   assign stackLevel      = stackLevel_q;
endmodule
`default_nettype wire

// ==== accumulator_load_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module accumulator_load_assertions #(
   parameter int PC_W  = 13,
   parameter int DEPTH = 8
) (
   input wire logic            clk,             // Clock
   input wire logic            rst_b,           // Reset
   input wire logic [9:0]      instr,           // Opcode
   input wire logic            instrValid,      // Opcode valid
   input wire logic [7:0]      timer4Val,       // Timer 4
   input wire logic [9:0]      convResult,      // Result
   input wire logic [3:0]      convCtrlFirst,   // Mode reg
   input wire logic [7:0]      generalReg,      // General reg
   input wire logic [3:0]      ramData,         // RAM word
   input wire logic [PC_W-1:0] pcIn,            // PC
   input wire logic [9:0]      romData,         // ROM word
   input wire logic [3:0]      accOut,          // Accumulator
   input wire logic [3:0]      compOut,         // Companion
   input wire logic [2:0]      pageIndexOut,    // Page index
   input wire logic [3:0]      rowIndexOut,     // Row index
   input wire logic [7:0]      compareRef,      // Reference
   input wire logic            compareRefWrite, // Ref pulse
   input wire logic [PC_W-1:0] romAddr,         // ROM address
   input wire logic            romRead,         // ROM strobe
   input wire logic            busy,            // Fetch busy
   input wire logic            pcRestore,       // PC reload
   input wire logic [PC_W-1:0] pcRestoreValue   // Reload value
);
   logic take;
   logic fetch;
   logic refWr;
   assign take  = instrValid && !busy;
   assign fetch = take && instr[9:6] == acc_load_pkg::OP_ROM_CONSTANT_FETCH_HI;
   assign refWr = take && instr == acc_load_pkg::OP_WRITE_COMPARE_REF;
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_b);

   timer_pair_a: assert property (
      take && instr == acc_load_pkg::OP_READ_TIMER4_PAIR
      |=> {compOut, accOut} == $past(timer4Val)) else $error("timer pair");
   conv_pair_a: assert property (
      take && instr == acc_load_pkg::OP_READ_CONVERSION_RESULT
      |=> {compOut, accOut} == ($past(convCtrlFirst[3]) ?
          $past(convResult[7:0]) : $past(convResult[9:2])))
      else $error("result pair");
   general_pair_a: assert property (
      take && instr == acc_load_pkg::OP_READ_GENERAL_PAIR
      |=> {compOut, accOut} == $past(generalReg)) else $error("general");
   page_read_a: assert property (
      take && instr == acc_load_pkg::OP_READ_PAGE_INDEX
      |=> accOut == {1'b0, $past(pageIndexOut)}) else $error("page read");
   low_bits_a: assert property (
      take && instr == acc_load_pkg::OP_READ_RESULT_LOW_BITS
      |=> accOut == {$past(convResult[1:0]), 2'b00}) else $error("low bits");
   ref_write_a: assert property (
      refWr && convCtrlFirst[3] |=> compareRefWrite
      && compareRef == $past({compOut, accOut})) else $error("ref write");
   ref_nop_a: assert property (
      refWr && !convCtrlFirst[3] |=> !compareRefWrite && $stable(compareRef))
      else $error("ref no-op");
   ram_load_a: assert property (
      take && instr[9:4] == acc_load_pkg::OP_LOAD_ACC_FROM_RAM_HI
      |=> accOut == $past(ramData)
      && rowIndexOut == ($past(rowIndexOut) ^ $past(instr[3:0])))
      else $error("ram load");
   rom_seq_a: assert property (
      fetch |=> romRead && busy ##1 !romRead && busy ##1 !busy && pcRestore
      && {compOut, accOut} == $past(romData[7:0])
      && pageIndexOut == {1'b0, $past(romData[9:8])}) else $error("rom seq");
   rom_addr_a: assert property (
      fetch |=> romAddr == {$past(instr[5:0]), $past(pageIndexOut),
      $past(accOut)}) else $error("rom address");
   pc_restore_a: assert property (
      fetch |-> ##3 pcRestoreValue == $past(pcIn, 3)) else $error("pc back");

   cover property (fetch);
   cover property (refWr && convCtrlFirst[3]);
   cover property (take && instr[9:4] == 6'h2c);
endmodule
bind accumulator_load_instructions accumulator_load_assertions #(
   .PC_W(PC_W), .DEPTH(DEPTH)) u_accumulator_load_assertions (.*);
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk, rst_b, instrValid, compareRefWrite, romRead, busy;
   logic        pcRestore;
   logic [9:0]  instr, convResult, romData;
   logic [7:0]  timer4Val, generalReg, prescalerVal, serialShift, compareRef;
   logic [3:0]  convCtrlFirst, intCtrlFirst, intCtrlSecond, serialCtrl;
   logic [3:0]  wakeCtrl0, wakeCtrl1, wakeCtrl2, clockCtrl, ramData;
   logic [3:0]  pullupCtrl0, pullupCtrl1, accOut, compOut, rowIndexOut;
   logic [2:0]  pageIndexOut, stackLevel;
   logic [12:0] pcIn, romAddr, pcRestoreValue;
   int          miscompares = 0;
   int          testsRun = 0;
   int          cycles = 0;

   accumulator_load_instructions u_accumulator_load_instructions (.*);

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         giveVerdict();
      end
   end

   task giveVerdict();
      if (miscompares == 0 && testsRun > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task check(input string name, input logic [15:0] seen,
              input logic [15:0] e);
      testsRun++;
      if (seen !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", name, e, seen);
         miscompares++;
      end
   endtask

   task exec(input logic [9:0] op);
      instr = op;
      instrValid = 1'b1;
      @(negedge clk);
   endtask

   task rd(input logic [9:0] op, input logic [7:0] e, input bit pair);
      exec(op);
      check("acc", accOut, e[3:0]);
      if (pair) check("comp", compOut, e[7:4]);
   endtask

   task romFetch(input logic [5:0] p, input logic [12:0] pc,
                 input logic [9:0] w, input logic [6:0] addrLow);
      pcIn = pc;
      romData = w;
      exec(10'h080 | p);
      instr = acc_load_pkg::OP_READ_GENERAL_PAIR;
      check("strobe", {romRead, busy}, 2'b11);
      check("romAddr", romAddr, {p, addrLow});
      @(negedge clk);
      instrValid = 1'b0;
      check("strobe", {romRead, busy}, 2'b01);
      @(negedge clk);
      check("load", {busy, pcRestore, compOut, accOut},
            {2'b01, w[7:0]});
      check("page", pageIndexOut, {1'b0, w[9:8]});
      check("pcBack", pcRestoreValue, pc);
      repeat (2) @(negedge clk);
      check("stack", stackLevel, 3'h7);
   endtask

   task readTable();
      rd(acc_load_pkg::OP_READ_TIMER4_PAIR, 8'h3c, 1);
      rd(acc_load_pkg::OP_READ_CONVERSION_RESULT, 8'had, 1);
      rd(acc_load_pkg::OP_READ_GENERAL_PAIR, 8'h5a, 1);
      rd(acc_load_pkg::OP_READ_PRESCALER, 8'h96, 1);
      rd(acc_load_pkg::OP_READ_SERIAL_SHIFT, 8'he1, 1);
      rd(acc_load_pkg::OP_READ_INT_CTRL_FIRST, 8'he1, 1);
      rd(acc_load_pkg::OP_READ_INT_CTRL_SECOND, 8'he2, 1);
      rd(acc_load_pkg::OP_READ_SERIAL_CTRL, 8'he3, 1);
      rd(acc_load_pkg::OP_READ_WAKE_CTRL_ZERO, 8'he4, 1);
      rd(acc_load_pkg::OP_READ_WAKE_CTRL_ONE, 8'he5, 1);
      rd(acc_load_pkg::OP_READ_WAKE_CTRL_TWO, 8'he6, 1);
      rd(acc_load_pkg::OP_READ_CLOCK_CTRL, 8'he7, 1);
      rd(acc_load_pkg::OP_READ_PULLUP_CTRL_ZERO, 8'he8, 1);
      rd(acc_load_pkg::OP_READ_PULLUP_CTRL_ONE, 8'he9, 1);
      rd(acc_load_pkg::OP_READ_RESULT_LOW_BITS, 8'hec, 1);
   endtask

   task compareTest();
      convCtrlFirst = 4'hb;
      rd(acc_load_pkg::OP_READ_CONVERSION_RESULT, 8'hb7, 1);
      exec(acc_load_pkg::OP_WRITE_COMPARE_REF);
      check("ref", {compareRefWrite, compareRef}, 9'h1b7);
      convCtrlFirst = 4'h3;
      rd(acc_load_pkg::OP_READ_GENERAL_PAIR, 8'h5a, 1);
      exec(acc_load_pkg::OP_WRITE_COMPARE_REF);
      check("refNop", {compareRefWrite, compareRef}, 9'h0b7);
      rd(acc_load_pkg::OP_READ_CONV_CTRL_FIRST, 8'h53, 1);
   endtask

   task ramTest();
      rd(10'h2c5, 8'h5d, 1);
      check("row", rowIndexOut, 4'h5);
      rd(10'h2cf, 8'h5d, 1);
      check("row", rowIndexOut, 4'ha);
   endtask

   initial begin
      {rst_b, instrValid, instr, pcIn, romData} = '0;
      {timer4Val, generalReg, prescalerVal, serialShift} = 32'h3c5a96e1;
      {convResult, convCtrlFirst, ramData} = {10'h2b7, 4'h3, 4'hd};
      {intCtrlFirst, intCtrlSecond, serialCtrl, wakeCtrl0} = 16'h1234;
      {wakeCtrl1, wakeCtrl2, clockCtrl, pullupCtrl0, pullupCtrl1} = 20'h56789;
      repeat (16) @(negedge clk);
      check("reset", {stackLevel, compareRef, accOut}, 15'h7000);
      rst_b = 1'b1;
      @(negedge clk);
      romFetch(6'h15, 13'h1abc, 10'h3a5, 7'h00);
      rd(acc_load_pkg::OP_READ_PAGE_INDEX, 8'ha3, 1);
      romFetch(6'h2a, 13'h0123, 10'h05e, 7'h33);
      readTable();
      compareTest();
      ramTest();
      instrValid = 1'b0;
      @(negedge clk);
      giveVerdict();
   end
endmodule
`default_nettype wire
